//--- hw/atts_consts.svh
/*
  Register offsets, field positions, reset values and widths for the
  adaptive threshold timeout and setup block.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef ATTS_CONSTS_SVH
`define ATTS_CONSTS_SVH

// ----------------------------------------------------------------
// Register pointers
// ----------------------------------------------------------------
`define ATTS_TMO1_ADDR     8'h0a
`define ATTS_SETUP1_ADDR   8'h0b
`define ATTS_TMO2_ADDR     8'h0d
`define ATTS_SETUP2_ADDR   8'h0e

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ATTS_TMO_RST       8'h86
`define ATTS_SETUP_RST     8'h0b

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATTS_APR_HI        7
`define ATTS_APR_LO        4
`define ATTS_REC_HI        3
`define ATTS_REC_LO        0
`define ATTS_SPAN_HI       7
`define ATTS_SPAN_LO       6
`define ATTS_HYST_BIT      4
`define ATTS_SETTLE_HI     3
`define ATTS_SETTLE_LO     0

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define ATTS_CNT_W         16
`define ATTS_FRAC_W        16
`define ATTS_AVG_W         28

`endif

//--- hw/atts_expiry_cnt.sv
/*
  One timeout counter, counted in finished conversions.
  Assumes conv_done is a one-cycle pulse per conversion of its channel.
*/
`timescale 1ns/10ps
`include "atts_consts.svh"

module atts_expiry_cnt
  import atts_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // Control
  input  wire logic                     conv_done,
  input  wire logic                     run,
  input  wire logic                     enable,
  input  wire logic                     clear,
  input  wire atts_pkg::atts_exp_t      expiry_exp,
  // Status
  output logic                          expired,
  output logic [`ATTS_CNT_W-1:0]        count
);

  logic [`ATTS_CNT_W-1:0] cnt_r;
  logic [`ATTS_CNT_W-1:0] cnt_nxt;
  logic [`ATTS_CNT_W-1:0] cnt_inc;
  logic [`ATTS_CNT_W-1:0] target;

  always_comb
  begin
    cnt_inc = cnt_r + 16'h0001;
    target  = 16'h0001 << expiry_exp;
    // Greater-or-equal so a lowered exponent still expires at once
    expired = conv_done & run & enable & (cnt_inc >= target);
    cnt_nxt = cnt_r;
    if (clear | ~enable)
      cnt_nxt = '0;
    else if (conv_done)
    begin
      if (run & ~expired)
        cnt_nxt = cnt_inc;
      else
        cnt_nxt = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign count = cnt_r;

endmodule

//--- hw/atts_pkg.sv
/*
  Types shared by the adaptive threshold timeout and setup block.
  Assumes nothing of its surroundings.
*/
package atts_pkg;

  // Comparator mode of the output comparator
  typedef enum logic [1:0] {
    ATTS_CMP_POS,
    ATTS_CMP_NEG,
    ATTS_CMP_WIN
  } atts_cmp_e;

  typedef logic [11:0] atts_data_t;
  typedef logic [7:0]  atts_byte_t;
  typedef logic [3:0]  atts_exp_t;

endpackage

//--- hw/atts_top.sv
/*
  Adaptive threshold timeout and setup logic for two channels: timeout and
  setup registers, running data average, timeout expiry and range decode.
  Assumes the serial interface delivers one-cycle register strobes and the
  converter delivers one-cycle done pulses with 12-bit results.
*/
// Notes on behaviour
// - Timeouts act only in adaptive threshold mode
// - Approaching count starts on crossing toward threshold
// - Approaching expires at two to upper nibble
// - Receding count starts crossing away, positive/negative
// - Window mode never uses receding timeout
// - Receding expires at two to lower nibble
// - Expiry loads average with newest result
// - Zero timeout register disables both timeouts
// - Timeout registers reset to 0x86
// - Setup registers reset to 0x0b
// - Range bits select auto offset step
// - Average moves by difference over two-power
// - Setup bit 4 disables adaptive hysteresis
`timescale 1ns/10ps
`include "atts_consts.svh"

module atts_top
  import atts_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  // Register port from the serial interface
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic [7:0]                    reg_rdata,
  // Mode from the configuration register
  input  wire logic                     thr_fixed,
  input  wire atts_pkg::atts_cmp_e      cmp_mode,
  // Conversion results and sensitivity per channel
  input  wire logic [1:0]               conv_done,
  input  wire atts_pkg::atts_data_t     conv_data [2],
  input  wire atts_pkg::atts_byte_t     sens [2],
  // Per-channel results
  output logic [15:0]                   data_average [2],
  output logic [1:0]                    input_span_sel [2],
  output logic [3:0]                    offset_cap_dac_step [2],
  output logic [1:0]                    hyst_enable,
  output logic [1:0]                    timeout_forced
);
  import atts_pkg::*;

  logic [7:0] setup_q [2];
  logic [7:0] tmo_q   [2];

  // ----------------------------------------------------------------
  // Per-channel registers, average and timeouts
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      localparam logic [7:0] SETUP_ADDR = (ch == 0) ? `ATTS_SETUP1_ADDR : `ATTS_SETUP2_ADDR;
      localparam logic [7:0] TMO_ADDR   = (ch == 0) ? `ATTS_TMO1_ADDR : `ATTS_TMO2_ADDR;

      logic [7:0]             setup_r;
      logic [7:0]             setup_nxt;
      logic [7:0]             tmo_r;
      logic [7:0]             tmo_nxt;
      logic [`ATTS_AVG_W-1:0] avg_r;
      logic [`ATTS_AVG_W-1:0] avg_nxt;
      logic [15:0]            avg_out_r;
      logic [15:0]            avg_out_nxt;
      logic [11:0]            avg12;
      logic                   above;
      logic                   below;
      logic                   apr_run;
      logic                   rec_run;
      logic                   tmo_en;
      logic                   apr_exp;
      logic                   rec_exp;
      logic                   force_avg;
      logic [`ATTS_CNT_W-1:0] apr_cnt;
      logic [`ATTS_CNT_W-1:0] rec_cnt;
      logic signed [28:0]     diff;
      logic signed [28:0]     step;
      logic signed [28:0]     sum;
      logic [4:0]             shamt;

      always_comb
      begin
        setup_nxt = setup_r;
        tmo_nxt   = tmo_r;
        if (reg_wr && reg_addr == SETUP_ADDR)
          setup_nxt = reg_wdata;
        if (reg_wr && reg_addr == TMO_ADDR)
          tmo_nxt = reg_wdata;
      end

      always_comb
      begin
        avg12   = avg_r[`ATTS_AVG_W-1:`ATTS_FRAC_W];
        above   = (conv_data[ch] > avg12) && ((conv_data[ch] - avg12) > {4'h0, sens[ch]});
        below   = (avg12 > conv_data[ch]) && ((avg12 - conv_data[ch]) > {4'h0, sens[ch]});
        tmo_en  = ~thr_fixed && (tmo_r != 8'h00);
        // Direction of the crossing depends on the comparator mode
        case (cmp_mode)
          ATTS_CMP_POS:
          begin
            apr_run = above;
            rec_run = below;
          end
          ATTS_CMP_NEG:
          begin
            apr_run = below;
            rec_run = above;
          end
          ATTS_CMP_WIN:
          begin
            apr_run = above | below;
            rec_run = 1'b0;
          end
          default:
          begin
            apr_run = 1'b0;
            rec_run = 1'b0;
          end
        endcase
      end

      atts_expiry_cnt u_apr (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .conv_done  (conv_done[ch]),
        .run        (apr_run),
        .enable     (tmo_en),
        .clear      (rec_exp),
        .expiry_exp (tmo_r[`ATTS_APR_HI:`ATTS_APR_LO]),
        .expired    (apr_exp),
        .count      (apr_cnt)
      );

      atts_expiry_cnt u_rec (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .conv_done  (conv_done[ch]),
        .run        (rec_run),
        .enable     (tmo_en),
        .clear      (apr_exp),
        .expiry_exp (tmo_r[`ATTS_REC_HI:`ATTS_REC_LO]),
        .expired    (rec_exp),
        .count      (rec_cnt)
      );

      always_comb
      begin
        force_avg = apr_exp | rec_exp;
        shamt     = {1'b0, setup_r[`ATTS_SETTLE_HI:`ATTS_SETTLE_LO]} + 5'h01;
        diff      = $signed({1'b0, conv_data[ch], 16'h0000}) - $signed({1'b0, avg_r});
        step      = diff >>> shamt;
        sum       = $signed({1'b0, avg_r}) + step;
        avg_nxt   = avg_r;
        if (conv_done[ch])
        begin
          if (force_avg)
            avg_nxt = {conv_data[ch], 16'h0000};
          else
            avg_nxt = sum[`ATTS_AVG_W-1:0];
        end
        avg_out_nxt = {avg_nxt[`ATTS_AVG_W-1:`ATTS_FRAC_W], 4'h0};
      end

      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          setup_r   <= `ATTS_SETUP_RST;
          tmo_r     <= `ATTS_TMO_RST;
          avg_r     <= '0;
          avg_out_r <= '0;
        end
        else
        begin
          setup_r   <= setup_nxt;
          tmo_r     <= tmo_nxt;
          avg_r     <= avg_nxt;
          avg_out_r <= avg_out_nxt;
        end
      end

      always_comb
      begin
        setup_q[ch]             = setup_r;
        tmo_q[ch]               = tmo_r;
        data_average[ch]        = avg_out_r;
        timeout_forced[ch]      = conv_done[ch] & force_avg;
        input_span_sel[ch]      = setup_r[`ATTS_SPAN_HI:`ATTS_SPAN_LO];
        hyst_enable[ch]         = ~thr_fixed & ~setup_r[`ATTS_HYST_BIT];
        case (setup_r[`ATTS_SPAN_HI:`ATTS_SPAN_LO])
          2'h0:    offset_cap_dac_step[ch] = 4'h4;
          2'h1:    offset_cap_dac_step[ch] = 4'h1;
          2'h2:    offset_cap_dac_step[ch] = 4'h2;
          default: offset_cap_dac_step[ch] = 4'h8;
        endcase
      end

      // ----------------------------------------------------------------
      // Checks
      // ----------------------------------------------------------------
      sequence s_expiry;
        conv_done[ch] && force_avg;
      endsequence
      sequence s_loaded;
        ##1 avg_out_r == {$past(conv_data[ch]), 4'h0};
      endsequence
      property p_force_loads;
        @(posedge mclk) disable iff (sys_rst) s_expiry |-> s_loaded;
      endproperty
      a_force_loads: assert property (p_force_loads) else $error("average not forced");
      property p_fixed_no_force;
        @(posedge mclk) disable iff (sys_rst) thr_fixed |-> !timeout_forced[ch];
      endproperty
      a_fixed_no_force: assert property (p_fixed_no_force) else $error("timeout in fixed mode");
      property p_zero_no_force;
        @(posedge mclk) disable iff (sys_rst) (tmo_r == 8'h00) |-> !timeout_forced[ch];
      endproperty
      a_zero_no_force: assert property (p_zero_no_force) else $error("zero register timed out");
      property p_win_no_rec;
        @(posedge mclk) disable iff (sys_rst) (cmp_mode == ATTS_CMP_WIN) |-> !rec_exp;
      endproperty
      a_win_no_rec: assert property (p_win_no_rec) else $error("receding in window mode");
      property p_apr_one;
        @(posedge mclk) disable iff (sys_rst)
          (conv_done[ch] && tmo_en && apr_run && tmo_r[7:4] == 4'h0) |-> apr_exp;
      endproperty
      a_apr_one: assert property (p_apr_one) else $error("approach exponent 0 missed");
      property p_rec_one;
        @(posedge mclk) disable iff (sys_rst)
          (conv_done[ch] && tmo_en && rec_run && tmo_r[3:0] == 4'h0) |-> rec_exp;
      endproperty
      a_rec_one: assert property (p_rec_one) else $error("recede exponent 0 missed");
      property p_setup_wr;
        @(posedge mclk) disable iff (sys_rst)
          (reg_wr && reg_addr == SETUP_ADDR) |=> setup_r == $past(reg_wdata);
      endproperty
      a_setup_wr: assert property (p_setup_wr) else $error("setup write lost");
      property p_dac_step;
        @(posedge mclk) disable iff (sys_rst)
          (setup_r[7:6] == 2'h1) |-> offset_cap_dac_step[ch] == 4'h1;
      endproperty
      a_dac_step: assert property (p_dac_step) else $error("wrong offset step");
      property p_hyst;
        @(posedge mclk) disable iff (sys_rst) thr_fixed |-> !hyst_enable[ch];
      endproperty
      a_hyst: assert property (p_hyst) else $error("hysteresis in fixed mode");
      property p_reentry_no_force;
        @(posedge mclk) disable iff (sys_rst)
          (conv_done[ch] && !above && !below) |=> (apr_cnt == '0 && rec_cnt == '0);
      endproperty
      a_reentry_no_force: assert property (p_reentry_no_force) else $error("forced inside band");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_rd)
    begin
      case (reg_addr)
        `ATTS_SETUP1_ADDR: rdata_nxt = setup_q[0];
        `ATTS_SETUP2_ADDR: rdata_nxt = setup_q[1];
        `ATTS_TMO1_ADDR:   rdata_nxt = tmo_q[0];
        `ATTS_TMO2_ADDR:   rdata_nxt = tmo_q[1];
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

endmodule

//--- test/tb_atts_top.sv
/*
  Self-checking bench for atts_top: register reset values, range decode,
  hysteresis enable, running average and both timeouts on each channel.
  Assumes atts_pkg and atts_consts.svh are compiled ahead of this file.
*/
`timescale 1ns/10ps

module tb_atts_top
  import atts_pkg::*;
;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        thr_fixed = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  atts_cmp_e   cmp_mode = ATTS_CMP_POS;
  logic [1:0]  conv_done = 2'h0;
  atts_data_t  conv_data [2] = '{12'h000, 12'h000};
  atts_byte_t  sens [2] = '{8'h10, 8'h10};
  logic [15:0] data_average [2];
  logic [1:0]  input_span_sel [2];
  logic [3:0]  offset_cap_dac_step [2];
  logic [1:0]  hyst_enable;
  logic [1:0]  timeout_forced;
  int          n_fail = 0;
  int          check_count = 0;
  int          ch;
  logic [7:0]  ta;
  logic [7:0]  sa;
  logic [3:0]  steps [4] = '{4'h4, 4'h1, 4'h2, 4'h8};

  always #20 mclk = ~mclk;

  atts_top i_atts_top (
    .mclk                (mclk),
    .sys_rst             (sys_rst),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_rdata           (reg_rdata),
    .thr_fixed           (thr_fixed),
    .cmp_mode            (cmp_mode),
    .conv_done           (conv_done),
    .conv_data           (conv_data),
    .sens                (sens),
    .data_average        (data_average),
    .input_span_sel      (input_span_sel),
    .offset_cap_dac_step (offset_cap_dac_step),
    .hyst_enable         (hyst_enable),
    .timeout_forced      (timeout_forced)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task end_sim;
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task rst;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
  endtask

  task mode(input atts_cmp_e m, input logic f);
    @(posedge mclk);
    cmp_mode  <= m;
    thr_fixed <= f;
  endtask

  // One conversion; the forced flag is combinational with the done pulse
  task conv(input logic [11:0] d, input logic f);
    @(posedge mclk);
    conv_done[ch] <= 1'b1;
    conv_data[ch] <= d;
    @(negedge mclk);
    chk("timeout_forced", {15'h0000, timeout_forced[ch]}, {15'h0000, f});
    @(posedge mclk);
    conv_done[ch] <= 1'b0;
  endtask

  task avg(input logic [15:0] e);
    @(negedge mclk);
    chk("data_average", data_average[ch], e);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    rst();
    rd(ta, 8'h86);
    rd(sa, 8'h0b);
    rd(8'h0c, 8'h00);
    chk("input_span_sel", {14'h0000, input_span_sel[ch]}, 16'h0000);
    chk("offset_cap_dac_step", {12'h000, offset_cap_dac_step[ch]}, 16'h0004);
    chk("hyst_enable", {15'h0000, hyst_enable[ch]}, 16'h0001);
  endtask

  task t_range;
    for (int k = 0; k < 4; k++)
    begin
      wr(sa, {k[1:0], 6'h00});
      @(negedge mclk);
      chk("input_span_sel", {14'h0000, input_span_sel[ch]}, {14'h0000, k[1:0]});
      chk("offset_cap_dac_step", {12'h000, offset_cap_dac_step[ch]}, {12'h000, steps[k]});
    end
    wr(sa, 8'h3f);
    rd(sa, 8'h3f);
    chk("hyst_enable", {15'h0000, hyst_enable[ch]}, 16'h0000);
    wr(sa, 8'h00);
    mode(ATTS_CMP_POS, 1'b1);
    @(negedge mclk);
    chk("hyst_enable", {15'h0000, hyst_enable[ch]}, 16'h0000);
    mode(ATTS_CMP_POS, 1'b0);
  endtask

  task t_average;
    rst();
    wr(sa, 8'h00);
    wr(ta, 8'h00);
    conv(12'h0f0, 1'b0);
    avg(16'h0780);
    conv(12'h0f0, 1'b0);
    avg(16'h0b40);
  endtask

  task t_approach;
    rst();
    wr(sa, 8'h0f);
    wr(ta, 8'h20);
    repeat (3) conv(12'h100, 1'b0);
    conv(12'h100, 1'b1);
    avg(16'h1000);
    conv(12'h000, 1'b1);
    avg(16'h0000);
  endtask

  task t_modes;
    rst();
    wr(sa, 8'h0f);
    wr(ta, 8'h0f);
    conv(12'h100, 1'b1);
    mode(ATTS_CMP_NEG, 1'b0);
    conv(12'h000, 1'b1);
    wr(ta, 8'hf0);
    mode(ATTS_CMP_WIN, 1'b0);
    repeat (2) conv(12'h100, 1'b0);
    mode(ATTS_CMP_NEG, 1'b0);
    conv(12'h100, 1'b1);
    mode(ATTS_CMP_POS, 1'b0);
  endtask

  task t_fixed;
    rst();
    wr(sa, 8'h0f);
    wr(ta, 8'h20);
    mode(ATTS_CMP_POS, 1'b1);
    repeat (5) conv(12'h100, 1'b0);
    mode(ATTS_CMP_POS, 1'b0);
    rst();
    wr(sa, 8'h0f);
    wr(ta, 8'h20);
    repeat (3) conv(12'h100, 1'b0);
    conv(12'h005, 1'b0);
    repeat (3) conv(12'h100, 1'b0);
    conv(12'h100, 1'b1);
    repeat (3) conv(12'h200, 1'b0);
    conv(12'h200, 1'b1);
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      ch = c;
      ta = (c == 0) ? 8'h0a : 8'h0d;
      sa = (c == 0) ? 8'h0b : 8'h0e;
      t_reset();
      t_range();
      t_average();
      t_approach();
      t_modes();
      t_fixed();
    end
    end_sim();
  end

  initial
  begin
    #400000;
    n_fail++;
    end_sim();
  end
endmodule
